// ### rtl/cond_eval.sv
// Jump condition evaluation from a 4-bit condition code.
// Only C, Z, S, V reach this module, so no other flag can be tested.
`timescale 1ns/10ps
module cond_eval (
  input wire logic [3:0] cc,
  input wire logic c,
  input wire logic z,
  input wire logic s,
  input wire logic v,
  output logic take
);
  always_comb
  begin
    // Upper half of the code space is the negation of the lower half
    unique case (cc[2:0])
      3'h0: take = 1'b0;
      3'h1: take = s ^ v;
      3'h2: take = z | (s ^ v);
      3'h3: take = c | z;
      3'h4: take = v;
      3'h5: take = s;
      3'h6: take = z;
      3'h7: take = c;
    endcase
    if (cc[3])
    begin
      take = ~take;
    end
  end
endmodule : cond_eval

// ### rtl/logic_test_trap_flags_ops.sv
// Execution block for test, exclusive-OR, trap and interrupt return with the flags register.
// Assumes an APB master on pclk; instructions are posted by software, not fetched.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
module logic_test_trap_flags_ops (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ************************************************
  // State
  // ************************************************
  ltx_pkg::state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] opc_r, op1_r, op2_r, op3_r;
  logic int_r, ill_seen_r;
  logic [3:0] flen_last_r, cc_r;
  logic [15:0] pc_r, sp_r;
  logic [7:2] flags_r;
  logic [1:0] user_r;
  logic [7:0] madr_r;
  logic [7:0] mem_r [0:255];
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  // ************************************************
  // Decode
  // ************************************************
  logic [3:0] form, grp, cycles, flen;
  logic is_test, is_xor, is_trap, interrupt_return_op, watchdog_refresh_op;
  logic is_ill, push, use_imm, finish;
  logic [7:0] dst_a, src_a, sval, dval, res, vec, vaddr, vaddr1, sp8;
  logic [7:0] sp_m1, sp_m2, sp_m3, sp_p1, sp_p2, flags_byte;
  logic zero, sign, take, busy, acc, acc_wr, idle_wr;
  logic [15:0] pc_ret;

  function automatic logic [7:0] work(input logic [3:0] n);
    work = {ltx_pkg::WORK_PAGE, n};
  endfunction : work

  always_comb
  begin
    form = opc_r[3:0];
    grp = opc_r[7:4];
    is_test = (grp == ltx_pkg::GRP_TEST) && (form >= ltx_pkg::FORM_FIRST)
      && (form <= ltx_pkg::FORM_LAST);
    is_xor = (grp == ltx_pkg::GRP_XOR) && (form >= ltx_pkg::FORM_FIRST)
      && (form <= ltx_pkg::FORM_LAST);
    is_trap = (opc_r == ltx_pkg::OPC_TRAP);
    interrupt_return_op = (opc_r == ltx_pkg::OPC_INTERRUPT_RETURN);
    watchdog_refresh_op = (opc_r == ltx_pkg::OPC_WATCHDOG_REFRESH);
    is_ill = !int_r && !(is_test || is_xor || is_trap || interrupt_return_op
      || watchdog_refresh_op);
    dst_a = 8'h00;
    src_a = 8'h00;
    use_imm = 1'b0;
    // Operand layout by addressing form
    unique case (form)
      4'h2:
      begin
        dst_a = work(op1_r[7:4]);
        src_a = work(op1_r[3:0]);
      end
      4'h3:
      begin
        dst_a = work(op1_r[7:4]);
        src_a = mem_r[work(op1_r[3:0])];
      end
      4'h4:
      begin
        src_a = op1_r;
        dst_a = op2_r;
      end
      4'h5:
      begin
        src_a = mem_r[op1_r];
        dst_a = op2_r;
      end
      4'h6:
      begin
        dst_a = op1_r;
        use_imm = 1'b1;
      end
      4'h7:
      begin
        dst_a = mem_r[op1_r];
        use_imm = 1'b1;
      end
      // Extended 12-bit addresses: only the low byte reaches this memory
      4'h8:
      begin
        src_a = {op1_r[3:0], op2_r[7:4]};
        dst_a = op3_r;
      end
      4'h9:
      begin
        dst_a = op3_r;
      end
      default:
      begin
        dst_a = 8'h00;
      end
    endcase
    if (form == 4'h9)
    begin
      sval = op1_r;
    end
    else
    begin
      sval = use_imm ? op2_r : mem_r[src_a];
    end
    dval = mem_r[dst_a];
    if (int_r || is_trap || is_ill)
    begin
      cycles = ltx_pkg::CYC_TRAP;
      flen = int_r ? 4'h0 : (is_trap ? ltx_pkg::LEN_REG : ltx_pkg::LEN_ONE);
    end
    else if (interrupt_return_op)
    begin
      cycles = ltx_pkg::CYC_INTERRUPT_RETURN;
      flen = ltx_pkg::LEN_ONE;
    end
    else if (watchdog_refresh_op)
    begin
      cycles = ltx_pkg::CYC_WATCHDOG_REFRESH;
      flen = ltx_pkg::LEN_ONE;
    end
    else if (form >= ltx_pkg::FORM_EXT)
    begin
      cycles = ltx_pkg::CYC_EXT;
      flen = ltx_pkg::LEN_EXT;
    end
    else
    begin
      cycles = form[0] ? ltx_pkg::CYC_LONG : ltx_pkg::CYC_SHORT;
      flen = (form < 4'h4) ? ltx_pkg::LEN_REG : ltx_pkg::LEN_FULL;
    end
    push = int_r || is_trap || is_ill;
    vec = (int_r || is_trap) ? op1_r : ltx_pkg::ILL_VEC;
    vaddr = {vec[6:0], 1'b0};
    vaddr1 = {vec[6:0], 1'b1};
    sp8 = sp_r[7:0];
    sp_m1 = sp8 - 8'h01;
    sp_m2 = sp8 - 8'h02;
    sp_m3 = sp8 - 8'h03;
    sp_p1 = sp8 + 8'h01;
    sp_p2 = sp8 + 8'h02;
    pc_ret = pc_r + {12'h000, flen};
    flags_byte = {flags_r, user_r};
    busy = (state_r == ltx_pkg::ST_RUN);
    finish = busy && (cnt_r == 4'h0);
    acc = psel && penable && pready_r;
    acc_wr = acc && pwrite && !pslverr_r;
    idle_wr = acc_wr && !busy;
  end

  logic_unit alu (
    .op_xor(is_xor),
    .a(dval),
    .b(sval),
    .res(res),
    .zero(zero),
    .sign(sign)
  );

  cond_eval cond (
    .cc(cc_r),
    .c(flags_r[ltx_pkg::FL_C]),
    .z(flags_r[ltx_pkg::FL_Z]),
    .s(flags_r[ltx_pkg::FL_S]),
    .v(flags_r[ltx_pkg::FL_V]),
    .take(take)
  );

  // ************************************************
  // Sequencer
  // ************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ltx_pkg::ST_IDLE;
      cnt_r <= 4'h0;
    end
    else if (!busy && idle_wr && paddr == ltx_pkg::ADDR_CTRL
      && (pwdata[ltx_pkg::CTRL_GO] || pwdata[ltx_pkg::CTRL_INT]))
    begin
      state_r <= ltx_pkg::ST_RUN;
      // Entry length from the request itself: int_r is set only at this edge
      cnt_r <= (pwdata[ltx_pkg::CTRL_INT] ? ltx_pkg::CYC_TRAP : cycles) - 4'h1;
    end
    else if (finish)
    begin
      state_r <= ltx_pkg::ST_IDLE;
    end
    else if (busy)
    begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // ************************************************
  // Software-posted instruction and control
  // ************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opc_r <= 8'h00;
      op1_r <= 8'h00;
      op2_r <= 8'h00;
      op3_r <= 8'h00;
      int_r <= 1'b0;
      cc_r <= 4'h0;
      madr_r <= 8'h00;
      ill_seen_r <= 1'b0;
      flen_last_r <= 4'h0;
    end
    else
    begin
      if (idle_wr && paddr == ltx_pkg::ADDR_OPC)
        opc_r <= pwdata[7:0];
      if (idle_wr && paddr == ltx_pkg::ADDR_OPND)
      begin
        op1_r <= pwdata[7:0];
        op2_r <= pwdata[15:8];
        op3_r <= pwdata[23:16];
      end
      if (idle_wr && paddr == ltx_pkg::ADDR_CTRL)
        int_r <= pwdata[ltx_pkg::CTRL_INT];
      else if (finish)
        int_r <= 1'b0;
      if (acc_wr && paddr == ltx_pkg::ADDR_COND)
        cc_r <= pwdata[3:0];
      if (acc_wr && paddr == ltx_pkg::ADDR_MADR)
        madr_r <= pwdata[7:0];
      // An illegal-opcode trap that lands with the clear keeps the flag set
      if (finish && is_ill)
        ill_seen_r <= 1'b1;
      else if (acc_wr && paddr == ltx_pkg::ADDR_CTRL && pwdata[ltx_pkg::CTRL_CLR_ILL])
        ill_seen_r <= 1'b0;
      if (finish)
        flen_last_r <= flen;
    end
  end

  // ************************************************
  // Program counter and stack pointer
  // ************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_r <= ltx_pkg::PC_RST;
      sp_r <= ltx_pkg::SP_RST;
    end
    else if (finish && push)
    begin
      pc_r <= {mem_r[vaddr], mem_r[vaddr1]};
      sp_r <= sp_r - 16'h0003;
    end
    else if (finish && interrupt_return_op)
    begin
      pc_r <= {mem_r[sp_p1], mem_r[sp_p2]};
      sp_r <= sp_r + 16'h0003;
    end
    else if (finish)
    begin
      pc_r <= pc_ret;
    end
    else if (idle_wr && paddr == ltx_pkg::ADDR_PC)
    begin
      pc_r <= pwdata[15:0];
    end
    else if (idle_wr && paddr == ltx_pkg::ADDR_SP)
    begin
      sp_r <= pwdata[15:0];
    end
  end

  // ************************************************
  // Flags
  // ************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= ltx_pkg::FLAGS_RST;
    end
    else if (finish && (is_test || is_xor) && !int_r)
    begin
      flags_r[ltx_pkg::FL_Z] <= zero;
      flags_r[ltx_pkg::FL_S] <= sign;
      flags_r[ltx_pkg::FL_V] <= 1'b0;
    end
    else if (finish && interrupt_return_op)
    begin
      flags_r <= mem_r[sp8][7:2];
    end
    else if (idle_wr && paddr == ltx_pkg::ADDR_FLAGS)
    begin
      flags_r <= pwdata[7:2];
    end
  end

  // No reset: user bits keep whatever they held
  always_ff @(posedge pclk)
  begin
    if (finish && interrupt_return_op)
      user_r <= mem_r[sp8][1:0];
    else if (idle_wr && paddr == ltx_pkg::ADDR_FLAGS)
      user_r <= pwdata[1:0];
  end

  // ************************************************
  // Data memory and stack
  // ************************************************
  always_ff @(posedge pclk)
  begin
    if (finish && is_xor && !int_r)
    begin
      mem_r[dst_a] <= res;
    end
    else if (finish && push)
    begin
      mem_r[sp_m2] <= pc_ret[15:8];
      mem_r[sp_m1] <= pc_ret[7:0];
      mem_r[sp_m3] <= flags_byte;
    end
    else if (idle_wr && paddr == ltx_pkg::ADDR_MDAT)
    begin
      mem_r[madr_r] <= pwdata[7:0];
    end
  end

  // ************************************************
  // APB slave: one wait state on every access
  // ************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r)
      begin
        pslverr_r <= (paddr > ltx_pkg::ADDR_COND) || (paddr[1:0] != 2'b00);
        unique case (paddr)
          ltx_pkg::ADDR_OPC: prdata_r <= {24'h000000, opc_r};
          ltx_pkg::ADDR_OPND: prdata_r <= {8'h00, op3_r, op2_r, op1_r};
          ltx_pkg::ADDR_STAT: prdata_r <= {24'h000000, flen_last_r, 2'b00, ill_seen_r, busy};
          ltx_pkg::ADDR_FLAGS: prdata_r <= {24'h000000, flags_byte};
          ltx_pkg::ADDR_PC: prdata_r <= {16'h0000, pc_r};
          ltx_pkg::ADDR_SP: prdata_r <= {16'h0000, sp_r};
          ltx_pkg::ADDR_MADR: prdata_r <= {24'h000000, madr_r};
          ltx_pkg::ADDR_MDAT: prdata_r <= {24'h000000, mem_r[madr_r]};
          ltx_pkg::ADDR_COND: prdata_r <= {27'h0000000, take, cc_r};
          default: prdata_r <= 32'h00000000;
        endcase
      end
      else
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ************************************************
  // Checks
  // ************************************************
  test_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && is_test && !int_r |=> !flags_r[ltx_pkg::FL_V]
      && flags_r[ltx_pkg::FL_Z] == $past(zero)
      && flags_r[ltx_pkg::FL_C] == $past(flags_r[ltx_pkg::FL_C])
      && flags_r[3:2] == $past(flags_r[3:2]))
    else $error("test op flag update wrong");
  test_keeps_dst_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && is_test && !int_r |=> mem_r[$past(dst_a)] == $past(dval))
    else $error("test op modified destination");
  ext_cycles_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && form >= ltx_pkg::FORM_EXT && (is_test || is_xor) && !int_r
      |-> busy[*3] ##1 !busy)
    else $error("extended op not three cycles");
  xor_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && is_xor && !int_r |=> mem_r[$past(dst_a)] == ($past(dval) ^ $past(sval))
      && !flags_r[ltx_pkg::FL_V])
    else $error("xor result not written");
  trap_cycles_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && push |-> busy[*6] ##1 !busy)
    else $error("trap not six cycles");
  trap_stack_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && is_trap && !int_r |=> sp_r == $past(sp_r) - 16'h0003
      && mem_r[sp_r[7:0] + 8'h01] == $past(pc_ret[15:8]))
    else $error("trap stack frame wrong");
  user_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && (is_test || is_xor) |=> user_r == $past(user_r))
    else $error("user flags changed by arithmetic");
  push_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && push |=> mem_r[sp_r[7:0]] == $past(flags_byte))
    else $error("flags not pushed");
  int_return_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && interrupt_return_op && !int_r |=> flags_byte == $past(mem_r[sp8]))
    else $error("flags not restored on return");

endmodule : logic_test_trap_flags_ops

// ### rtl/logic_unit.sv
// Byte AND / XOR with zero and sign results.
// Purely combinational; caller registers results.
`timescale 1ns/10ps
module logic_unit (
  input wire logic op_xor,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] res,
  output logic zero,
  output logic sign
);
  always_comb
  begin
    res = op_xor ? (a ^ b) : (a & b);
    zero = (res == 8'h00);
    sign = res[7];
  end
endmodule : logic_unit

// ### rtl/ltx_pkg.sv
// Constants, register map and types for the logic/trap/flags execution block.
// Assumes a single pclk domain and an APB master with 32-bit data.
// Behaviour
// - Test ANDs operands, sets Z S, clears V.
// - Extended test opcodes 78/79, four bytes, three cycles.
// - Exclusive-OR writes result, sets Z S, clears V.
// - Extended exclusive-OR opcodes B8/B9, three cycles.
// - Trap pushes PC, pushes flags, loads vector.
// - Flags register holds six operation status bits.
// - Jump conditions test only carry, overflow, zero, sign.
// - Half-carry and decimal flags never jump conditions.
// - User flags change only by explicit writes and interrupt return.
// - User flags never usable as jump conditions.
// - User flags uninitialised, untouched by reset.
// - Interrupt, trap, illegal trap push flags.
// - Interrupt return reloads flags from stack.
package ltx_pkg;

  // ************************************************
  // Register map (byte addresses)
  // ************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPC = 8'h04;
  localparam logic [7:0] ADDR_OPND = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_SP = 8'h18;
  localparam logic [7:0] ADDR_MADR = 8'h1c;
  localparam logic [7:0] ADDR_MDAT = 8'h20;
  localparam logic [7:0] ADDR_COND = 8'h24;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int CTRL_GO = 0;
  localparam int CTRL_INT = 1;
  localparam int CTRL_CLR_ILL = 2;
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_D = 3;
  localparam int FL_H = 2;

  // ************************************************
  // Opcodes
  // ************************************************
  localparam logic [3:0] GRP_TEST = 4'h7;
  localparam logic [3:0] GRP_XOR = 4'hb;
  localparam logic [3:0] FORM_FIRST = 4'h2;
  localparam logic [3:0] FORM_EXT = 4'h8;
  localparam logic [3:0] FORM_LAST = 4'h9;
  localparam logic [7:0] OPC_TRAP = 8'hf2;
  localparam logic [7:0] OPC_INTERRUPT_RETURN = 8'hbf;
  localparam logic [7:0] OPC_WATCHDOG_REFRESH = 8'h5f;
  localparam logic [3:0] WORK_PAGE = 4'he;
  localparam logic [7:0] ILL_VEC = 8'h00;

  // ************************************************
  // Cycle counts and fetch lengths
  // ************************************************
  localparam logic [3:0] CYC_SHORT = 4'h3;
  localparam logic [3:0] CYC_LONG = 4'h4;
  localparam logic [3:0] CYC_EXT = 4'h3;
  localparam logic [3:0] CYC_TRAP = 4'h6;
  localparam logic [3:0] CYC_INTERRUPT_RETURN = 4'h5;
  localparam logic [3:0] CYC_WATCHDOG_REFRESH = 4'h2;
  localparam logic [3:0] LEN_REG = 4'h2;
  localparam logic [3:0] LEN_FULL = 4'h3;
  localparam logic [3:0] LEN_EXT = 4'h4;
  localparam logic [3:0] LEN_ONE = 4'h1;

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

endpackage : ltx_pkg

// ### verif/logic_test_trap_flags_ops_tb_top.sv
// Self-checking bench for the logic, trap and flags execution block.
// Assumes the block is the only APB slave on pclk and answers each access on its own.
`timescale 1ns/10ps
module logic_test_trap_flags_ops_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  int n_mismatch;
  int tests_run;

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

  logic_test_trap_flags_ops i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Idle cycle after each transfer so no signal is driven twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
    wr(ltx_pkg::ADDR_MADR, {24'h0, a});
    wr(ltx_pkg::ADDR_MDAT, {24'h0, d});
  endtask : mem_wr

  task automatic mem_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wr(ltx_pkg::ADDR_MADR, {24'h0, a});
    rd(ltx_pkg::ADDR_MDAT, q);
    `CHK(q, {24'h0, e})
  endtask : mem_chk

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    `CHK(q, e)
  endtask : reg_chk

  task automatic start(input logic [31:0] ctl, input logic [7:0] opc, input logic [23:0] od);
    wr(ltx_pkg::ADDR_OPC, {24'h0, opc});
    wr(ltx_pkg::ADDR_OPND, {8'h0, od});
    wr(ltx_pkg::ADDR_CTRL, ctl);
  endtask : start

  task automatic wait_idle;
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 20)
    begin
      rd(ltx_pkg::ADDR_STAT, q);
      n++;
    end
    if (n >= 20) n_mismatch++;
  endtask : wait_idle

  function automatic logic exp_take(input logic [3:0] cc, input logic [7:0] f);
    logic t;
    case (cc[2:0])
      3'd0: t = 1'b0;
      3'd1: t = f[5] ^ f[4];
      3'd2: t = f[6] | (f[5] ^ f[4]);
      3'd3: t = f[7] | f[6];
      3'd4: t = f[4];
      3'd5: t = f[5];
      3'd6: t = f[6];
      default: t = f[7];
    endcase
    return t ^ cc[3];
  endfunction : exp_take

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Whole run needs a few thousand cycles
  initial
  begin
    #500000;
    n_mismatch++;
    report_and_stop;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin : main
    logic [31:0] q;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] p;
    logic [7:0] r;
    logic [23:0] od;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    last_err = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ltx_pkg::ADDR_FLAGS, q);
    `CHK(q[7:2], 6'h00)
    reg_chk(ltx_pkg::ADDR_PC, 32'h0);
    $display("Reset values done");
    for (int g = 0; g < 2; g++)
      for (int k = 0; k < 2; k++)
        for (int fm = 2; fm < 10; fm++)
        begin
          d = k ? 8'hf0 : 8'ha5;
          s = k ? 8'h0f : 8'hc3;
          p = k ? 8'h60 : 8'h9f;
          r = g ? (d ^ s) : (d & s);
          mem_wr(8'he1, d);
          mem_wr(8'he2, s);
          mem_wr(8'he3, 8'he2);
          mem_wr(8'he4, 8'he1);
          wr(ltx_pkg::ADDR_FLAGS, {24'h0, p});
          case (fm)
            2: od = 24'h000012;
            3: od = 24'h000013;
            4: od = 24'h00e1e2;
            5: od = 24'h00e1e3;
            6: od = {8'h00, s, 8'he1};
            7: od = {8'h00, s, 8'he4};
            8: od = 24'he1200e;
            default: od = {8'he1, 8'h00, s};
          endcase
          start(32'h1, {(g ? ltx_pkg::GRP_XOR : ltx_pkg::GRP_TEST), 4'(fm)}, od);
          wait_idle;
          rd(ltx_pkg::ADDR_FLAGS, q);
          `CHK(q[7:0], ((p & 8'h8f) | {1'b0, r == 8'h00, r[7], 5'h00}))
          mem_chk(8'he1, g ? r : d);
          mem_chk(8'he2, s);
          rd(ltx_pkg::ADDR_STAT, q);
          `CHK(q[7:4], (fm < 4 ? ltx_pkg::LEN_REG : (fm < 8 ? ltx_pkg::LEN_FULL : ltx_pkg::LEN_EXT)))
        end
    $display("Test and exclusive-OR forms done");
    wr(ltx_pkg::ADDR_SP, 32'h80);
    wr(ltx_pkg::ADDR_PC, 32'h1234);
    wr(ltx_pkg::ADDR_FLAGS, 32'hc5);
    mem_wr(8'h06, 8'h45);
    mem_wr(8'h07, 8'h67);
    start(32'h1, ltx_pkg::OPC_TRAP, 24'h000003);
    // Flags write while busy must be dropped
    wr(ltx_pkg::ADDR_FLAGS, 32'h00);
    wait_idle;
    reg_chk(ltx_pkg::ADDR_SP, 32'h7d);
    reg_chk(ltx_pkg::ADDR_PC, 32'h4567);
    mem_chk(8'h7e, 8'h12);
    mem_chk(8'h7f, 8'h36);
    mem_chk(8'h7d, 8'hc5);
    reg_chk(ltx_pkg::ADDR_FLAGS, 32'hc5);
    reg_chk(ltx_pkg::ADDR_OPC, {24'h0, ltx_pkg::OPC_TRAP});
    reg_chk(ltx_pkg::ADDR_OPND, 32'h3);
    reg_chk(ltx_pkg::ADDR_MADR, 32'h7d);
    wr(ltx_pkg::ADDR_FLAGS, 32'h00);
    start(32'h1, ltx_pkg::OPC_INTERRUPT_RETURN, 24'h0);
    wait_idle;
    reg_chk(ltx_pkg::ADDR_FLAGS, 32'hc5);
    reg_chk(ltx_pkg::ADDR_PC, 32'h1236);
    reg_chk(ltx_pkg::ADDR_SP, 32'h80);
    $display("Trap and return done");
    wr(ltx_pkg::ADDR_FLAGS, 32'h3a);
    // Test opcode left posted: entry must still push and take six cycles
    start(32'h1 << ltx_pkg::CTRL_INT, 8'h72, 24'h000003);
    wait_idle;
    mem_chk(8'h7d, 8'h3a);
    mem_chk(8'h7f, 8'h36);
    reg_chk(ltx_pkg::ADDR_PC, 32'h4567);
    wr(ltx_pkg::ADDR_FLAGS, 32'h55);
    mem_wr(8'h00, 8'h0a);
    mem_wr(8'h01, 8'hbc);
    start(32'h1, 8'h70, 24'h0);
    wait_idle;
    mem_chk(8'h7a, 8'h55);
    mem_chk(8'h7c, 8'h68);
    reg_chk(ltx_pkg::ADDR_PC, 32'h0abc);
    rd(ltx_pkg::ADDR_STAT, q);
    `CHK(q[1], 1'b1)
    wr(ltx_pkg::ADDR_CTRL, 32'h1 << ltx_pkg::CTRL_CLR_ILL);
    rd(ltx_pkg::ADDR_STAT, q);
    `CHK(q[1], 1'b0)
    start(32'h1, ltx_pkg::OPC_WATCHDOG_REFRESH, 24'h0);
    wait_idle;
    reg_chk(ltx_pkg::ADDR_FLAGS, 32'h55);
    $display("Interrupt, illegal and refresh done");
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 0) ? 8'h0f : ((i == 1) ? 8'hf0 : ((i == 2) ? 8'ha0 : 8'h53));
      wr(ltx_pkg::ADDR_FLAGS, {24'h0, p});
      for (int cc = 0; cc < 16; cc++)
      begin
        wr(ltx_pkg::ADDR_COND, {28'h0, 4'(cc)});
        rd(ltx_pkg::ADDR_COND, q);
        `CHK(q[4:0], {exp_take(4'(cc), p), 4'(cc)})
      end
    end
    $display("Jump conditions done");
    rd(8'h28, q);
    `CHK({last_err, q}, {1'b1, 32'h0})
    wr(ltx_pkg::ADDR_FLAGS, 32'hfe);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_chk(ltx_pkg::ADDR_FLAGS, 32'h02);
    reg_chk(ltx_pkg::ADDR_SP, 32'h0);
    $display("Second reset done");
    report_and_stop;
  end
endmodule : logic_test_trap_flags_ops_tb_top
